//--- tb/sed_core_sva.sv
`timescale 1ns/1ps
module sed_core_chk (
  input wire sys_clk,
  input wire reset_n,
  input wire csN,
  input wire sclk,
  input wire soOut,
  input wire soOe,
  input wire memWrEn
);
  // ----------------------------------------------------------------
  // Link-side relations
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  property p_oe_idle;
    csN [*4] |-> !soOe;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("output driven outside a frame");
  property p_quiet_idle;
    csN [*4] |-> !memWrEn;
  endproperty
  a_quiet_idle: assert property (p_quiet_idle) else $error("write strobe outside a frame");
  // Bytes arrive at least nine system clocks apart
  property p_wr_gap;
    memWrEn |=> !memWrEn [*8];
  endproperty
  a_wr_gap: assert property (p_wr_gap) else $error("write strobe too long or too close");
  property p_wr_in_frame;
    memWrEn |-> !$past(csN, 2);
  endproperty
  a_wr_in_frame: assert property (p_wr_in_frame) else $error("write strobe without select");
  property p_wr_no_out;
    memWrEn |-> !soOe;
  endproperty
  a_wr_no_out: assert property (p_wr_no_out) else $error("output driven during a write");
  property p_so_on_fall;
    soOe && $past(soOe) && $changed(soOut) |-> !sclk;
  endproperty
  a_so_on_fall: assert property (p_so_on_fall) else $error("output changed while clock high");
  property p_so_hold_high;
    soOe && $past(soOe) && sclk && $past(sclk) |-> $stable(soOut);
  endproperty
  a_so_hold_high: assert property (p_so_hold_high) else $error("output moved in high phase");
  property p_oe_in_frame;
    soOe |-> !$past(csN, 2);
  endproperty
  a_oe_in_frame: assert property (p_oe_in_frame) else $error("output driven without select");

  c_write: cover property (memWrEn);
  c_read: cover property ($rose(soOe));
  c_release: cover property ($fell(soOe));
endmodule

//--- tb/sed_spi_master.sv
`timescale 1ns/1ps
module sed_spi_master (
  input  wire  sys_clk,
  input  wire  soOut,
  input  wire  soOe,
  output logic csN,
  output logic sclk,
  output logic mosi
);
  // ----------------------------------------------------------------
  // Mode 0 master, half period of 8 system clocks
  // ----------------------------------------------------------------
  localparam int HALF = 8;
  logic oeSeen;
  initial begin
    csN = 1'b1;
    sclk = 1'b0;
    mosi = 1'b1;
    oeSeen = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Returns the last two bytes seen; a released output reads as a toggling level
  task automatic frame(input logic [7:0] tx[$], output logic [15:0] rx);
    logic lastSo;
    lastSo = 1'b0;
    rx = 16'h0;
    oeSeen = 1'b0;
    csN <= 1'b0;
    tick(HALF);
    foreach (tx[i]) begin
      for (int b = 7; b >= 0; b--) begin
        mosi <= tx[i][b];
        tick(HALF);
        sclk <= 1'b1;
        lastSo = soOe ? soOut : ~lastSo;
        oeSeen = oeSeen | soOe;
        rx = {rx[14:0], lastSo};
        tick(HALF);
        sclk <= 1'b0;
      end
    end
    tick(HALF);
    csN <= 1'b1;
    mosi <= ~mosi;
    tick(HALF);
  endtask
endmodule

//--- tb/sed_tb.sv
`timescale 1ns/1ps
module testbench;
  // ----------------------------------------------------------------
  // Harness
  // ----------------------------------------------------------------
  localparam int WCYC = 1500;
  logic sys_clk = 1'b0, reset_n = 1'b0, clkEn = 1'b1, wpN = 1'b1;
  logic [7:0] wrData = 8'h00;
  logic [15:0] rx, wrAddr = 16'h0;
  wire csN, sclk, mosi, soOut, soOe, memIdSel, memWrEn;
  wire [15:0] memAddr;
  wire [7:0] memWrData, memRdData;
  int errCount = 0, checked = 0, wrCount = 0;
  logic [15:0] addrs[3] = '{16'h1fff, 16'h2000, 16'h3000};
  always #4 sys_clk = ~sys_clk;
  // Combinational read: the core takes data one cycle after the address moves
  assign memRdData = memAddr[7:0] ^ (memIdSel ? 8'h3c : 8'ha5);
  always @(posedge sys_clk) begin
    if (memWrEn) begin
      wrCount <= wrCount + 1;
      wrAddr <= memAddr;
      wrData <= memWrData;
    end
  end
  sed_core #(.WRITE_CYCLES(WCYC)) sed_core_i (.sys_clk(sys_clk), .reset_n(reset_n), .clkEn(clkEn), .csN(csN),
    .sclk(sclk), .mosi(mosi), .wpN(wpN), .memRdData(memRdData), .soOut(soOut), .soOe(soOe), .memAddr(memAddr),
    .memIdSel(memIdSel), .memWrEn(memWrEn), .memWrData(memWrData));
  sed_spi_master sed_spi_master_i (.sys_clk(sys_clk), .soOut(soOut), .soOe(soOe), .csN(csN), .sclk(sclk),
    .mosi(mosi));

  task automatic completeRun();
    $display("Comparisons %0d, mismatches %0d", checked, errCount);
    if (errCount == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      errCount++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic send(input logic [7:0] tx[$]);
    sed_spi_master_i.frame(tx, rx);
  endtask
  task automatic stat(input logic [7:0] exp);
    send('{8'h05, 8'h00});
    cmp({8'h0, rx[7:0]}, {8'h0, exp});
  endtask
  // Polls the busy flag a bounded number of times
  task automatic idle();
    for (int i = 0; i < 20; i++) begin
      send('{8'h05, 8'h00});
      if (rx[0] === 1'b0) return;
    end
    errCount++;
    $display("MISMATCH t=%0t busy=%h exp=%h", $time, rx, 16'h0);
    completeRun();
  endtask
  task automatic arrWr(input logic [15:0] a, input logic [7:0] d, input int expN);
    int n;
    n = wrCount;
    send('{8'h06});
    send('{8'h02, a[15:8], a[7:0], d});
    idle();
    cmp(16'(wrCount - n), 16'(expN));
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_latch();
    stat(8'h00);
    send('{8'hff, 8'h00, 8'h00});
    cmp({15'h0, sed_spi_master_i.oeSeen}, 16'h0);
    send('{8'h01, 8'h8c});
    stat(8'h00);
    send('{8'h06});
    stat(8'h02);
    send('{8'h04});
    stat(8'h00);
    send('{8'h0e});
    stat(8'h02);
    send('{8'h0c});
    stat(8'h00);
    send('{8'h06});
    @(posedge sys_clk) reset_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (10) @(posedge sys_clk);
    stat(8'h00);
  endtask
  task automatic t_status();
    send('{8'h06});
    send('{8'h01, 8'hfc});
    stat(8'hff);
    send('{8'h03, 8'h00, 8'h00, 8'h00});
    cmp({15'h0, sed_spi_master_i.oeSeen}, 16'h0);
    send('{8'h06});
    idle();
    stat(8'h8c);
    @(posedge sys_clk) wpN <= 1'b0;
    send('{8'h06});
    send('{8'h01, 8'h00});
    stat(8'h8e);
    @(posedge sys_clk) wpN <= 1'b1;
    send('{8'h01, 8'h00});
    idle();
    stat(8'h00);
  endtask
  task automatic t_protect();
    int n;
    for (int lv = 0; lv < 4; lv++) begin
      send('{8'h06});
      send('{8'h01, {4'h0, lv[1:0], 2'b00}});
      idle();
      foreach (addrs[k]) begin
        arrWr(addrs[k], 8'h5a, (lv == 3 || (lv == 2 && k > 0) || (lv == 1 && k == 2)) ? 0 : 1);
      end
    end
    send('{8'h06});
    send('{8'h01, 8'h00});
    idle();
    arrWr(16'h0020, 8'h77, 1);
    cmp(wrAddr, 16'h0020);
    cmp({8'h0, wrData}, 16'h0077);
    stat(8'h00);
    n = wrCount;
    send('{8'h02, 8'h00, 8'h10, 8'h5a});
    cmp(16'(wrCount - n), 16'h0);
  endtask
  task automatic t_read();
    int n;
    send('{8'h03, 8'h12, 8'h34, 8'h00, 8'h00});
    cmp(rx, {8'h34 ^ 8'ha5, 8'h35 ^ 8'ha5});
    send('{8'h83, 8'h00, 8'h05, 8'h00});
    cmp({8'h0, rx[7:0]}, {8'h0, 8'h05 ^ 8'h3c});
    send('{8'h82, 8'h04, 8'h00, 8'h00, 8'h00});
    cmp(rx, 16'h0000);
    n = wrCount;
    send('{8'h06});
    send('{8'h82, 8'h00, 8'h01, 8'h66});
    idle();
    cmp(16'(wrCount - n), 16'h1);
    send('{8'h06});
    send('{8'h82, 8'h04, 8'h00, 8'h02, 8'h02});
    send('{8'h82, 8'h04, 8'h00, 8'h00, 8'h00});
    cmp(rx, 16'h0000);
    send('{8'h06});
    send('{8'h82, 8'h04, 8'h00, 8'h02});
    idle();
    send('{8'h82, 8'hff, 8'hff, 8'h00, 8'h00});
    cmp(rx, 16'h0101);
    n = wrCount;
    send('{8'h06});
    send('{8'h82, 8'h00, 8'h01, 8'h66});
    idle();
    cmp(16'(wrCount - n), 16'h0);
  endtask

  initial begin
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (10) @(posedge sys_clk);
    t_latch();
    t_status();
    t_protect();
    t_read();
    completeRun();
  end
endmodule

bind sed_core sed_core_chk sed_core_chk_i (.sys_clk(sys_clk), .reset_n(reset_n), .csN(csN), .sclk(sclk),
  .soOut(soOut), .soOe(soOe), .memWrEn(memWrEn));

//--- verilog/sed_busy_timer.v
`timescale 1ns/1ps
module sed_busy_timer #(
  parameter CW     = 20,
  parameter CYCLES = 625000
) (
  input  wire sys_clk,
  input  wire rstN,
  input  wire clkEn,
  input  wire start,
  output wire busy,
  output wire done
);
  reg [CW-1:0] cnt_q;
  reg          busy_q;

  always @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      cnt_q  <= {CW{1'b0}};
      busy_q <= 1'b0;
    end else if (clkEn) begin
      if (start && !busy_q) begin
        cnt_q  <= CYCLES[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};
        busy_q <= 1'b1;
      end else if (busy_q) begin
        if (cnt_q == {CW{1'b0}})
          busy_q <= 1'b0;
        else
          cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

  assign busy = busy_q;
  assign done = clkEn && busy_q && (cnt_q == {CW{1'b0}});
endmodule

//--- verilog/sed_consts.vh
// Function
// (RL1) Status writes ignored: latch clear or hardware-protected
// (RL2) Bit 0 busy; busy accepts only status read
// (RL3) Latch clear refuses all status/array changes
// (RL4) Set-latch command sets; power-up clears latch
// (RL5) Bits 2-3 protect level, start zero
// (RL6) Bits 4-6 written but not stored, read 0
// (RL7) Arm bit plus low pin: status read-only
// (RL8) Arm 1-to-0 refused while pin low
// (RL9) Whole status reads ones during write cycle
// (RL10) Protect level decodes to upper quarter/half/all
// (RL11) Chip select low; sample input on rise
// (RL12) After opcode: address/data; output on fall
// (RL13) All bytes travel most significant bit first
// (RL14) Chip select rise starts operation, then standby
// (RL15) Set/clear latch opcodes, no address or data
// (RL16) Array read/write opcodes with 16-bit address
// (RL17) Identification page read with address
// (RL18) Identification page write with address, data
// (RL19) Lock-status read chosen by address bit
// (RL20) Lock command with address and data byte
// (RL21) Don't-care opcode bit ignored when decoding
// (RL22) Page access needs address bit 10 zero
// (RL23) Lock commands need address bit 10 one
// (RL24) Latch cleared after clear, status, array writes
// (RL25) Lock state in output byte bit 0
// (RL26) Unknown opcode: no action, output stays off
// (RL27) Status write applied at byte boundary, busy
//
`ifndef SED_CONSTS_VH
`define SED_CONSTS_VH

// ----------------------------------------------------------------
// Opcodes, bit 3 is a don't-care
// ----------------------------------------------------------------
`define SED_OP_SET_LATCH   8'h06
`define SED_OP_CLR_LATCH   8'h04
`define SED_OP_STATUS_RD   8'h05
`define SED_OP_STATUS_WR   8'h01
`define SED_OP_ARRAY_RD    8'h03
`define SED_OP_ARRAY_WR    8'h02
`define SED_OP_ID_RD       8'h83
`define SED_OP_ID_X        8'h82

// ----------------------------------------------------------------
// Status register layout
// ----------------------------------------------------------------
`define SED_ST_BUSY        0
`define SED_ST_LATCH       1
`define SED_ST_BP_LO       2
`define SED_ST_BP_HI       3
`define SED_ST_ARM         7
`define SED_ST_BUSY_VIEW   8'hff
`define SED_BP_RESET       2'h0
`define SED_ADDR_A10       10
`define SED_LOCK_DATA_BIT  1

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SED_SYS_CLK_NS     8
`define SED_WRITE_CYCLE_NS 5000000

`endif

//--- verilog/sed_core.v
`timescale 1ns/1ps
`include "sed_consts.vh"
module sed_core #(
  parameter WRITE_CYCLES = `SED_WRITE_CYCLE_NS / `SED_SYS_CLK_NS,
  parameter TIMER_W      = 20
) (
  input  wire        sys_clk,
  input  wire        reset_n,
  input  wire        clkEn,
  input  wire        csN,
  input  wire        sclk,
  input  wire        mosi,
  input  wire        wpN,
  input  wire [7:0]  memRdData,
  output wire        soOut,
  output wire        soOe,
  output wire [15:0] memAddr,
  output wire        memIdSel,
  output wire        memWrEn,
  output wire [7:0]  memWrData
);

  // ----------------------------------------------------------------
  // Command classes
  // ----------------------------------------------------------------
  localparam [3:0] CMD_NONE  = 4'h0;
  localparam [3:0] CMD_SETL  = 4'h1;
  localparam [3:0] CMD_CLRL  = 4'h2;
  localparam [3:0] CMD_STRD  = 4'h3;
  localparam [3:0] CMD_STWR  = 4'h4;
  localparam [3:0] CMD_ARRD  = 4'h5;
  localparam [3:0] CMD_ARWR  = 4'h6;
  localparam [3:0] CMD_IDRD  = 4'h7;
  localparam [3:0] CMD_IDX   = 4'h8;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function opMatch;
    input [7:0] op;
    input [7:0] code;
    begin
      opMatch = ({op[7:4], op[2:0]} == {code[7:4], code[2:0]}); // RL21
    end
  endfunction

  function isProtected;
    input [15:0] addr;
    input [1:0]  level;
    begin
      case (level)
        2'h1:    isProtected = (addr[13:12] == 2'h3); // RL10
        2'h2:    isProtected = addr[13];              // RL10
        2'h3:    isProtected = 1'b1;                  // RL10
        default: isProtected = 1'b0;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------
  reg  [1:0] rstSync_q;
  wire       rstN;
  wire [3:0] pinSync;
  wire       csS;
  wire       sclkS;
  wire       mosiS;
  wire       wpS;

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)
      rstSync_q <= 2'h0;
    else
      rstSync_q <= {rstSync_q[0], 1'b1};
  end
  assign rstN = rstSync_q[1];

  sed_sync #(
    .W (4)
  ) u_sync (
    .sys_clk (sys_clk),
    .rstN    (rstN),
    .clkEn   (clkEn),
    .asyncIn ({csN, sclk, mosi, wpN}),
    .syncOut (pinSync)
  );
  assign csS   = pinSync[3];
  assign sclkS = pinSync[2];
  assign mosiS = pinSync[1];
  assign wpS   = pinSync[0];

  // ----------------------------------------------------------------
  // Edge detection on synchronised pins
  // ----------------------------------------------------------------
  reg  sclkPrev_q;
  reg  csPrev_q;
  wire sclkRise;
  wire sclkFall;
  wire csRise;

  always @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      sclkPrev_q <= 1'b0;
      csPrev_q   <= 1'b1;
    end else if (clkEn) begin
      sclkPrev_q <= sclkS;
      csPrev_q   <= csS;
    end
  end

  assign sclkRise = clkEn && !csS && sclkS && !sclkPrev_q; // RL11
  assign sclkFall = clkEn && !csS && !sclkS && sclkPrev_q;
  assign csRise   = clkEn && csS && !csPrev_q;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg  [2:0]  bitCnt_q;
  reg  [2:0]  byteCnt_q;
  reg  [7:0]  shift_q;
  reg  [3:0]  cmd_q;
  reg  [15:0] addr_q;
  reg  [7:0]  data_q;
  reg  [7:0]  outByte_q;
  reg         outEn_q;
  reg         so_q;
  reg         loadPend_q;
  reg         wroteAny_q;
  reg         advPend_q;
  reg         idSel_q;
  reg         set_write_latch_cmd_q;
  reg  [7:0]  wrData_q;
  reg         latch_q;
  reg  [1:0]  bp_q;
  reg         arm_q;
  reg         lock_q;
  reg         pendStatus_q;
  reg         pendLock_q;
  reg  [7:0]  stData_q;

  wire [7:0]  byteVal;
  wire        byteDone;
  wire        hwProt;
  wire        busy;
  wire        wrDone;
  wire        a10;
  wire [7:0]  statusView;
  reg         startWr;
  reg         latchSet;
  reg         latchClr;
  reg         takeStatus;
  reg         takeLock;

  assign byteVal  = {shift_q[6:0], mosiS};                   // RL13
  assign byteDone = sclkRise && (bitCnt_q == 3'h7);
  assign hwProt   = arm_q && !wpS;                           // RL7
  assign a10      = addr_q[`SED_ADDR_A10];

  // Don't-care bits read 0; a write cycle shows all ones
  assign statusView = busy ? `SED_ST_BUSY_VIEW :             // RL9
                      {arm_q, 3'h0, bp_q, latch_q, 1'b0};    // RL2 RL6

  // ----------------------------------------------------------------
  // Self-timed write cycle
  // ----------------------------------------------------------------
  sed_busy_timer #(
    .CW     (TIMER_W),
    .CYCLES (WRITE_CYCLES)
  ) u_timer (
    .sys_clk (sys_clk),
    .rstN    (rstN),
    .clkEn   (clkEn),
    .start   (startWr),
    .busy    (busy),
    .done    (wrDone)
  );

  // ----------------------------------------------------------------
  // End-of-frame decisions on the chip select rise
  // ----------------------------------------------------------------
  always @* begin
    startWr    = 1'b0;
    latchSet   = 1'b0;
    latchClr   = 1'b0;
    takeStatus = 1'b0;
    takeLock   = 1'b0;
    if (csRise && (bitCnt_q == 3'h0)) begin                  // RL14
      case (cmd_q)
        CMD_SETL: latchSet = (byteCnt_q == 3'h1);            // RL15 RL4
        CMD_CLRL: latchClr = (byteCnt_q == 3'h1);            // RL15 RL24
        CMD_STWR: begin
          // Arm cannot drop while pin low; whole write refused then
          if ((byteCnt_q == 3'h2) && latch_q && !hwProt &&   // RL1 RL3 RL27
              !(arm_q && !stData_q[`SED_ST_ARM] && !wpS)) begin // RL8
            takeStatus = 1'b1;
            startWr    = 1'b1;
          end
        end
        CMD_ARWR: startWr = wroteAny_q;
        CMD_IDX: begin
          if (!a10)
            startWr = wroteAny_q;                            // RL18
          else if ((byteCnt_q == 3'h4) && data_q[`SED_LOCK_DATA_BIT] &&
                   latch_q && !lock_q) begin                 // RL20 RL23
            takeLock = 1'b1;
            startWr  = 1'b1;
          end
        end
        default: startWr = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Status register and lock state
  // ----------------------------------------------------------------
  always @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      latch_q      <= 1'b0;                                  // RL4
      bp_q         <= `SED_BP_RESET;                         // RL5
      arm_q        <= 1'b0;
      lock_q       <= 1'b0;
      pendStatus_q <= 1'b0;
      pendLock_q   <= 1'b0;
      stData_q     <= 8'h00;
    end else if (clkEn) begin
      if (byteDone && (cmd_q == CMD_STWR) && (byteCnt_q == 3'h1))
        stData_q <= byteVal;
      if (takeStatus)
        pendStatus_q <= 1'b1;
      if (takeLock)
        pendLock_q <= 1'b1;
      if (wrDone) begin
        // Stored values change only when the cycle completes
        if (pendStatus_q) begin
          bp_q  <= stData_q[`SED_ST_BP_HI:`SED_ST_BP_LO];    // RL5 RL27
          arm_q <= stData_q[`SED_ST_ARM];                    // RL7
        end
        if (pendLock_q)
          lock_q <= 1'b1;                                    // RL20
        pendStatus_q <= 1'b0;
        pendLock_q   <= 1'b0;
      end
      if (latchSet)
        latch_q <= 1'b1;
      else if (latchClr || wrDone)
        latch_q <= 1'b0;                                     // RL24
    end
  end

  // ----------------------------------------------------------------
  // Serial shifter and opcode decode
  // ----------------------------------------------------------------
  always @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      bitCnt_q   <= 3'h0;
      byteCnt_q  <= 3'h0;
      shift_q    <= 8'h00;
      cmd_q      <= CMD_NONE;
      addr_q     <= 16'h0000;
      data_q     <= 8'h00;
      outByte_q  <= 8'h00;
      outEn_q    <= 1'b0;
      loadPend_q <= 1'b0;
      wroteAny_q <= 1'b0;
      advPend_q  <= 1'b0;
      idSel_q    <= 1'b0;
      set_write_latch_cmd_q     <= 1'b0;
      wrData_q   <= 8'h00;
    end else if (clkEn) begin
      set_write_latch_cmd_q <= 1'b0;
      // Address moves on after the strobe, so each write sees its own address
      if (advPend_q) begin
        advPend_q   <= 1'b0;
        addr_q[5:0] <= addr_q[5:0] + 6'h01;
      end
      if (csS) begin
        // Deselected: back to standby, output released
        bitCnt_q   <= 3'h0;
        byteCnt_q  <= 3'h0;
        cmd_q      <= CMD_NONE;
        outEn_q    <= 1'b0;
        loadPend_q <= 1'b0;
        wroteAny_q <= 1'b0;
      end else if (loadPend_q) begin
        // Read data is valid one cycle after the address settles
        loadPend_q <= 1'b0;
        outByte_q  <= memRdData;
        if (idSel_q)
          addr_q[5:0] <= addr_q[5:0] + 6'h01;
        else
          addr_q <= addr_q + 16'h0001;
      end else if (sclkRise) begin
        bitCnt_q <= bitCnt_q + 3'h1;                         // RL11
        shift_q  <= byteVal;                                 // RL13
        if (byteDone) begin
          // Counts one past the lock frame so a longer frame voids the lock
          if (byteCnt_q != 3'h5)
            byteCnt_q <= byteCnt_q + 3'h1;
          case (byteCnt_q)
            3'h0: begin                                      // RL12
              idSel_q <= 1'b0;
              if (opMatch(byteVal, `SED_OP_STATUS_RD)) begin
                cmd_q     <= CMD_STRD;
                outByte_q <= statusView;
                outEn_q   <= 1'b1;
              end else if (busy)
                cmd_q <= CMD_NONE;                           // RL2
              else if (opMatch(byteVal, `SED_OP_SET_LATCH))
                cmd_q <= CMD_SETL;                           // RL15
              else if (opMatch(byteVal, `SED_OP_CLR_LATCH))
                cmd_q <= CMD_CLRL;                           // RL15
              else if (opMatch(byteVal, `SED_OP_STATUS_WR))
                cmd_q <= CMD_STWR;                           // RL1
              else if (opMatch(byteVal, `SED_OP_ARRAY_RD))
                cmd_q <= CMD_ARRD;                           // RL16
              else if (opMatch(byteVal, `SED_OP_ARRAY_WR))
                cmd_q <= CMD_ARWR;                           // RL16
              else if (opMatch(byteVal, `SED_OP_ID_RD))
                cmd_q <= CMD_IDRD;                           // RL17
              else if (opMatch(byteVal, `SED_OP_ID_X))
                cmd_q <= CMD_IDX;                            // RL18 RL19
              else
                cmd_q <= CMD_NONE;                           // RL26
            end
            3'h1: begin
              if (cmd_q == CMD_STRD)
                outByte_q <= statusView;
              else
                addr_q[15:8] <= byteVal;
            end
            3'h2: begin
              if (cmd_q == CMD_STRD)
                outByte_q <= statusView;
              else
                addr_q[7:0] <= byteVal;
              if (cmd_q == CMD_ARRD) begin                   // RL16
                loadPend_q <= 1'b1;
                outEn_q    <= 1'b1;
              end else if ((cmd_q == CMD_IDRD) && !a10) begin // RL22 RL17
                idSel_q    <= 1'b1;
                loadPend_q <= 1'b1;
                outEn_q    <= 1'b1;
              end else if (cmd_q == CMD_IDX) begin
                if (a10) begin
                  outByte_q <= {7'h00, lock_q};              // RL25 RL19
                  outEn_q   <= 1'b1;
                end else
                  idSel_q <= 1'b1;                           // RL22
              end
            end
            default: begin
              data_q <= byteVal;
              case (cmd_q)
                CMD_STRD: outByte_q <= statusView;
                CMD_ARRD: loadPend_q <= 1'b1;
                CMD_IDRD: loadPend_q <= idSel_q;
                CMD_ARWR: begin
                  if (latch_q && !isProtected(addr_q, bp_q)) begin // RL3 RL10
                    set_write_latch_cmd_q     <= 1'b1;
                    wrData_q   <= byteVal;
                    wroteAny_q <= 1'b1;
                  end
                  advPend_q <= 1'b1;
                end
                CMD_IDX: begin
                  if (!a10 && latch_q && !lock_q) begin      // RL18 RL3
                    set_write_latch_cmd_q     <= 1'b1;
                    wrData_q   <= byteVal;
                    wroteAny_q <= 1'b1;
                  end
                  if (!a10)
                    advPend_q <= 1'b1;
                end
                default: data_q <= byteVal;
              endcase
            end
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial output, changes on the clock fall
  // ----------------------------------------------------------------
  always @(posedge sys_clk or negedge rstN) begin
    if (!rstN)
      so_q <= 1'b0;
    else if (clkEn && sclkFall && outEn_q)
      so_q <= outByte_q[3'h7 - bitCnt_q];                    // RL12 RL13
  end

  assign soOut     = so_q;
  assign soOe      = outEn_q && !csS;                        // RL26
  assign memAddr   = addr_q;
  assign memIdSel  = idSel_q;
  assign memWrEn   = set_write_latch_cmd_q;
  assign memWrData = wrData_q;

endmodule

//--- verilog/sed_sync.v
`timescale 1ns/1ps
module sed_sync #(
  parameter W = 4
) (
  input  wire         sys_clk,
  input  wire         rstN,
  input  wire         clkEn,
  input  wire [W-1:0] asyncIn,
  output wire [W-1:0] syncOut
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  // Inputs idle high so a reset does not look like a select
  always @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      meta_q <= {W{1'b1}};
      sync_q <= {W{1'b1}};
    end else if (clkEn) begin
      meta_q <= asyncIn;
      sync_q <= meta_q;
    end
  end

  assign syncOut = sync_q;
endmodule
